/* File: verilog/usdt_pkg.sv */
// Package of constants for the step/direction translator
package usdt_pkg;

  // ****************************************************************
  // Phase pattern layout: bit order {b2, a2, b1, a1}
  // ****************************************************************
  localparam int PH_A1 = 0;
  localparam int PH_B1 = 1;
  localparam int PH_A2 = 2;
  localparam int PH_B2 = 3;
  localparam logic [3:0] PAT_INIT = 4'h5;

  // ****************************************************************
  // Translator index: eight half-step positions, even ones are
  // two-phase positions shared with the full-step cycle
  // ****************************************************************
  localparam logic [2:0] IDX_INIT = 3'h0;
  localparam logic [2:0] IDX_HALF = 3'h1;
  localparam logic [2:0] IDX_FULL = 3'h2;

  // ****************************************************************
  // Reset values of the synchronisers and outputs
  // ****************************************************************
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam logic ORIGIN_RST = 1'b1;
  localparam logic ALARM_RST = 1'b1;

endpackage

/* File: verilog/usdt_sync.sv */
// Two-flop synchroniser for one asynchronous input pin
module usdt_sync
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic pin_in,
  output logic pin_sync
);
  import usdt_pkg::*;

  logic [1:0] sync_q;
  logic [1:0] sync_d;

  always_comb
  begin
    sync_d = {sync_q[0], pin_in};
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      sync_q <= SYNC_RST;
    else
      sync_q <= sync_d;
  end

  assign pin_sync = sync_q[1];

endmodule

/* File: verilog/usdt_translator.sv */
// Top of the unipolar step/direction translator
module usdt_translator
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic step_in,
  input wire logic direction_rev,
  input wire logic half_step_select,
  input wire logic enable,
  input wire logic translator_reset_n,
  input wire logic power_down_n,
  input wire logic thermal_trip,
  input wire logic undervoltage_trip,
  output logic phase_sink_a1,
  output logic phase_sink_b1,
  output logic phase_sink_a2,
  output logic phase_sink_b2,
  output logic origin_flag_n,
  output logic alarm_n
);
  import usdt_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Pins may float; the synchronisers reset to low, and
  // a low holds reset or standby on translator_reset_n and power_down_n, and is the inactive level on the rest.
  localparam int NIN = 8;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] syn_in;

  assign raw_in = {undervoltage_trip, thermal_trip, power_down_n,
                   translator_reset_n, enable, half_step_select,
                   direction_rev, step_in};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++)
    begin : g_sync
      usdt_sync u_sync
      (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .pin_in(raw_in[gi]),
        .pin_sync(syn_in[gi])
      );
    end
  endgenerate

  logic step_s;
  logic dir_s;
  logic half_s;
  logic en_s;
  logic rst_n_s;
  logic pd_n_s;
  logic trip_s;

  assign step_s = syn_in[0];
  assign dir_s = syn_in[1];
  assign half_s = syn_in[2];
  assign en_s = syn_in[3];
  assign rst_n_s = syn_in[4];
  assign pd_n_s = syn_in[5];
  assign trip_s = syn_in[6] | syn_in[7];

  // ****************************************************************
  // Step edge detect
  // ****************************************************************
  // Reset high, so the empty synchroniser gives no edge after reset.
  logic step_prev_q;
  logic step_prev_d;
  logic step_pulse;

  always_comb
  begin
    step_prev_d = step_s;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      step_prev_q <= 1'b1;
    else
      step_prev_q <= step_prev_d;
  end

  assign step_pulse = step_s & ~step_prev_q;

  // ****************************************************************
  // Translator index
  // ****************************************************************
  // Both select levels pass the same synchroniser depth as step, so
  // they are taken at the edge; changing them on the edge may
  // misstep, as the controller is told.
  logic [2:0] idx_q;
  logic [2:0] idx_d;
  logic [2:0] stride;
  logic hold_init;

  assign hold_init = ~rst_n_s | ~pd_n_s;

  always_comb
  begin
    stride = half_s ? IDX_HALF : IDX_FULL;
    idx_d = idx_q;
    if (hold_init)
      idx_d = IDX_INIT;
    else if (step_pulse)
    begin
      // Entering full mode on an odd index lands on the next pair.
      if (!half_s && idx_q[0])
        idx_d = dir_s ? (idx_q - IDX_HALF) : (idx_q + IDX_HALF);
      else if (dir_s)
        idx_d = idx_q - stride;
      else
        idx_d = idx_q + stride;
    end
  end

  // Enable does not enter here, so the index still follows step pulses while disabled.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      idx_q <= IDX_INIT;
    else
      idx_q <= idx_d;
  end

  // ****************************************************************
  // Pattern decode and output gating
  // ****************************************************************
  logic [3:0] pat;
  logic [3:0] ph_q;
  logic [3:0] ph_d;
  logic origin_q;
  logic origin_d;
  logic alarm_q;
  logic alarm_d;
  logic drive_ok;

  always_comb
  begin
    unique case (idx_q)
      3'h0: pat = PAT_INIT;
      3'h1: pat = 4'h4;
      3'h2: pat = 4'h6;
      3'h3: pat = 4'h2;
      3'h4: pat = 4'hA;
      3'h5: pat = 4'h8;
      3'h6: pat = 4'h9;
      3'h7: pat = 4'h1;
    endcase
  end

  assign drive_ok = en_s & rst_n_s & pd_n_s & ~trip_s;

  always_comb
  begin
    ph_d = drive_ok ? pat : 4'h0;
    // Pin level, active low. Taken from the same index as the phases,
    // so flag and pattern change on one edge. Power-down forces it low.
    origin_d = ~((idx_q == IDX_INIT) | ~pd_n_s);
    alarm_d = ~trip_s;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ph_q <= 4'h0;
      origin_q <= ORIGIN_RST;
      alarm_q <= ALARM_RST;
    end
    else
    begin
      ph_q <= ph_d;
      origin_q <= origin_d;
      alarm_q <= alarm_d;
    end
  end

  // Sink outputs are active high: 1 means the drain is sinking.
  assign phase_sink_a1 = ph_q[PH_A1];
  assign phase_sink_b1 = ph_q[PH_B1];
  assign phase_sink_a2 = ph_q[PH_A2];
  assign phase_sink_b2 = ph_q[PH_B2];
  assign origin_flag_n = origin_q;
  assign alarm_n = alarm_q;

endmodule

/* File: test/usdt_chk.sv */
// Port checker of the step/direction translator
module usdt_chk
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic step_in,
  input wire logic direction_rev,
  input wire logic half_step_select,
  input wire logic enable,
  input wire logic translator_reset_n,
  input wire logic power_down_n,
  input wire logic thermal_trip,
  input wire logic undervoltage_trip,
  input wire logic phase_sink_a1,
  input wire logic phase_sink_b1,
  input wire logic phase_sink_a2,
  input wire logic phase_sink_b2,
  input wire logic origin_flag_n,
  input wire logic alarm_n
);
  import usdt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  logic [3:0] ph;
  logic trip;
  logic run;
  assign ph = {phase_sink_b2, phase_sink_a2, phase_sink_b1, phase_sink_a1};
  assign trip = thermal_trip | undervoltage_trip;
  assign run = enable & translator_reset_n & power_down_n & !trip;
  // Seven quiet cycles cover sync plus output latency
  sequence quiet_s;
    ($stable(step_in) && run)[*7];
  endsequence
  sequence rel_s;
    $rose(translator_reset_n) ##0 run[*6];
  endsequence
  AST_EN: assert property
    ((!enable)[*4] |=> ph == 4'h0)
    else $error("enable gate");
  AST_RST: assert property
    ((!translator_reset_n)[*4] |=> ph == 4'h0)
    else $error("reset gate");
  AST_PD: assert property
    ((!power_down_n)[*4] |=> ph == 4'h0 && !origin_flag_n)
    else $error("standby");
  AST_TRIP: assert property
    (trip[*4] |=> ph == 4'h0 && !alarm_n)
    else $error("trip");
  AST_OK: assert property
    ((!trip)[*4] |=> alarm_n)
    else $error("alarm");
  AST_ORG: assert property
    (ph != 4'h0 |-> origin_flag_n == (ph != PAT_INIT))
    else $error("origin");
  AST_STEP: assert property
    ($rose(step_in) && run |-> ##[3:5] $changed(ph))
    else $error("no advance");
  AST_HOLD: assert property
    (quiet_s |-> $stable(ph))
    else $error("stray advance");
  AST_REL: assert property
    (rel_s |-> ph == PAT_INIT)
    else $error("release");
endmodule
bind usdt_translator usdt_chk chk_u (.*);

/* File: test/usdt_ctl_model.sv */
// Motion controller model giving step pulses with direction and mode
module usdt_ctl_model
(
  input wire logic ref_clk,
  output logic step_in = 1'b0,
  output logic direction_rev = 1'b0,
  output logic half_step_select = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Levels settle 4 cycles before the rise and hold past it
  task automatic pulse(input logic dir, input logic half);
    direction_rev = dir;
    half_step_select = half;
    repeat (4) @(negedge ref_clk);
    step_in = 1'b1;
    repeat (4) @(negedge ref_clk);
    step_in = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask
endmodule

/* File: test/tb.sv */
// Self-checking bench of the step/direction translator
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import usdt_pkg::*;
  `define CHK(nm, ex, got) \
    begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic enable = 1'b1;
  logic translator_reset_n = 1'b1;
  logic power_down_n = 1'b1;
  logic thermal_trip = 1'b0;
  logic undervoltage_trip = 1'b0;
  logic step_in, direction_rev, half_step_select;
  logic phase_sink_a1, phase_sink_b1, phase_sink_a2, phase_sink_b2;
  logic origin_flag_n, alarm_n;
  logic [3:0] ph_seen;
  assign ph_seen = {phase_sink_b2, phase_sink_a2, phase_sink_b1,
                    phase_sink_a1};
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam logic [3:0] PAT [8] = '{4'h5, 4'h4, 4'h6, 4'h2,
    4'hA, 4'h8, 4'h9, 4'h1};
  always #25 ref_clk = ~ref_clk;
  usdt_ctl_model ctl_u (.*);
  usdt_translator dut_u (.*);
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic look(input logic [3:0] ex, input logic org);
    repeat (6) @(negedge ref_clk);
    `CHK("phases", ex, ph_seen)
    `CHK("origin", org, origin_flag_n)
  endtask
  task automatic walk(input logic d, input logic h);
    int p;
    for (int i = 1; i <= 8; i++)
    begin
      ctl_u.pulse(d, h);
      p = (h ? i : 2 * i) % 8;
      p = d ? (8 - p) % 8 : p;
      look(PAT[p], p != 0);
    end
  endtask
  // Full mode taken at a single-phase index lands on the next pair
  task automatic t_mix();
    ctl_u.pulse(1'b0, 1'b1);
    look(4'h4, 1'b1);
    ctl_u.pulse(1'b0, 1'b0);
    look(4'h6, 1'b1);
    ctl_u.pulse(1'b1, 1'b1);
    look(4'h4, 1'b1);
    ctl_u.pulse(1'b1, 1'b0);
    look(PAT_INIT, 1'b0);
  endtask
  task automatic t_gate();
    enable = 1'b0;
    ctl_u.pulse(1'b0, 1'b0);
    look(4'h0, 1'b1);
    enable = 1'b1;
    look(4'h6, 1'b1);
    translator_reset_n = 1'b0;
    ctl_u.pulse(1'b0, 1'b0);
    look(4'h0, 1'b0);
    translator_reset_n = 1'b1;
    look(PAT_INIT, 1'b0);
    ctl_u.pulse(1'b1, 1'b1);
    look(4'h1, 1'b1);
    power_down_n = 1'b0;
    look(4'h0, 1'b0);
    power_down_n = 1'b1;
    look(PAT_INIT, 1'b0);
  endtask
  task automatic t_trip();
    for (int k = 0; k < 2; k++)
    begin
      {undervoltage_trip, thermal_trip} = k ? 2'h2 : 2'h1;
      look(4'h0, 1'b0);
      `CHK("alarm", 1'b0, alarm_n)
      {undervoltage_trip, thermal_trip} = 2'h0;
      look(PAT_INIT, 1'b0);
      `CHK("alarm", 1'b1, alarm_n)
    end
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      close_out();
    end
  end
  initial
  begin
    repeat (20) @(negedge ref_clk);
    arst_n = 1'b1;
    look(PAT_INIT, 1'b0);
    for (int m = 0; m < 4; m++)
      walk(m[0], m[1]);
    t_mix();
    t_gate();
    t_trip();
    close_out();
  end
endmodule
